//--- hw/dcs_regs.v
// How it works
// - any soft-reset write resets command state, decoder
// - soft-reset any value written means reset, bit0 not needed; resets zero
// - playback bit0, reset one, only while decoding
// - silence bit0, reset zero, clocks keep running
// - nonzero command write loads five-byte ancillary buffer
// - select bit2 chooses buffered clock or request
// - buffered clock equals crystal input clock frequency
// - sync state two bits; code 11 unused
// - sixteen-bit ancillary count, low byte first
// - header copy refreshed on every new sync
// - header copy fields at fixed bit positions
// - extended-version and version bits give variant
// - layer three header field always reads 01
// - protection bit one means no redundancy check
// - bitrate index decodes by version bit table
// - registers reached over control bus by address
`timescale 1ns/10ps
`include "dcs_map.vh"
module dcs_regs #(
   parameter [6:0] DEV_ADDR = 7'h43   // arbitrary bus address
) (
   // clock and reset
   input  wire        mclk,
   input  wire        rst_n,
   // control bus pins, open drain
   input  wire        sclIn,
   input  wire        sdaIn,
   output wire        sdaOut,
   output wire        sdaOe,
   // decoder core status
   input  wire        decoding,
   input  wire [1:0]  syncStateIn,
   input  wire        syncAchieved,
   input  wire [20:0] headerIn,
   input  wire        frameDecodedOk,
   input  wire [15:0] ancCountIn,
   input  wire [39:0] ancDataIn,
   // decoder core control
   output reg         softResetPulse,
   output wire        playActive,
   output wire        silenceOut,
   output reg         ancLatchPulse,
   // multimedia pin
   input  wire        crystalInputClock,
   input  wire        dataRequestIn,
   output wire        multimediaPin,
   // header decode
   output reg  [1:0]  standardVariant,
   output reg  [8:0]  bitrateKbps,
   output reg         bitrateFree,
   output reg         bitrateForbidden,
   output reg         layerThree,
   output reg         crcAbsent
);

   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_ACKA = 3'h2;
   localparam ST_WR   = 3'h3;
   localparam ST_ACKW = 3'h4;
   localparam ST_RD   = 3'h5;
   localparam ST_RACK = 3'h6;

   reg  [2:0]  state_ff;
   reg  [3:0]  bitCnt_ff;
   reg  [7:0]  shift_ff;
   reg  [7:0]  ptr_ff;
   reg         gotPtr_ff;
   reg         rnw_ff;
   reg         sdaOe_ff;
   reg         sclPrev_ff;
   reg         sdaPrev_ff;
   reg  [7:0]  play_ff;
   reg  [7:0]  silence_ff;
   reg  [7:0]  ancCmd_ff;
   reg  [7:0]  pinSel_ff;
   reg  [1:0]  syncState_ff;
   reg  [15:0] ancCount_ff;
   reg  [20:0] header_ff;
   reg  [39:0] ancBuf_ff;
   wire        wrStb;
   reg  [7:0]  rdData;
   wire        sclRise;
   wire        sclFall;
   wire        startCond;
   wire        stopCond;
   wire [7:0]  ancIdx;

   // bus edges and framing conditions
   assign sclRise   = sclIn & ~sclPrev_ff;
   assign sclFall   = ~sclIn & sclPrev_ff;
   assign startCond = sclIn & sclPrev_ff & sdaPrev_ff & ~sdaIn;
   assign stopCond  = sclIn & sclPrev_ff & ~sdaPrev_ff & sdaIn;
   assign sdaOut    = 1'b0;
   assign sdaOe     = sdaOe_ff;
   assign ancIdx    = ptr_ff - `DCS_ANC_BUF_FIRST;

   // read mux; reserved and write-only addresses read zero
   always @* begin
      rdData = 8'h00;
      case (ptr_ff)
         `DCS_PLAYBACK_REQUEST:        rdData = play_ff;
         `DCS_OUTPUT_SILENCE:          rdData = silence_ff;
         `DCS_ANCILLARY_LATCH_COMMAND: rdData = ancCmd_ff;
         `DCS_REQUEST_PIN_SELECT:      rdData = pinSel_ff;
         `DCS_FRAME_SYNC_STATE:        rdData = {6'h00, syncState_ff};
         `DCS_ANCILLARY_BITS_LOW:      rdData = ancCount_ff[7:0];
         `DCS_ANCILLARY_BITS_HIGH:     rdData = ancCount_ff[15:8];
         `DCS_FRAME_HEADER_UPPER:      rdData = {3'h0, header_ff[20:16]};
         `DCS_FRAME_HEADER_MIDDLE:     rdData = header_ff[15:8];
         `DCS_FRAME_HEADER_LOWER:      rdData = header_ff[7:0];
         default: if (ptr_ff >= `DCS_ANC_BUF_FIRST && ptr_ff <= `DCS_ANC_BUF_LAST) begin
            rdData = ancBuf_ff[ancIdx[2:0]*8 +: 8];
         end
      endcase
   end

   // data byte completes: first byte after address sets the pointer
   assign wrStb = (state_ff == ST_WR) && sclFall && (bitCnt_ff == 4'h8) && gotPtr_ff && !startCond && !stopCond;

   // control bus slave: 7-bit address, pointer byte, auto-increment
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff   <= ST_IDLE;
         bitCnt_ff  <= 4'd0;
         shift_ff   <= 8'h00;
         ptr_ff     <= 8'h00;
         gotPtr_ff  <= 1'b0;
         rnw_ff     <= 1'b0;
         sdaOe_ff   <= 1'b0;
         sclPrev_ff <= 1'b1;
         sdaPrev_ff <= 1'b1;
      end else begin
         sclPrev_ff <= sclIn;
         sdaPrev_ff <= sdaIn;
         if (startCond) begin
            state_ff  <= ST_ADDR;
            bitCnt_ff <= 4'd0;
            gotPtr_ff <= 1'b0;
            sdaOe_ff  <= 1'b0;
         end else if (stopCond) begin
            state_ff <= ST_IDLE;
            sdaOe_ff <= 1'b0;
         end else begin
            case (state_ff)
               ST_ADDR, ST_WR: begin
                  if (sclRise) begin
                     shift_ff  <= {shift_ff[6:0], sdaIn};
                     bitCnt_ff <= bitCnt_ff + 4'd1;
                  end else if (sclFall && bitCnt_ff == 4'd8) begin
                     bitCnt_ff <= 4'd0;
                     if (state_ff == ST_ADDR) begin
                        if (shift_ff[7:1] == DEV_ADDR) begin
                           rnw_ff   <= shift_ff[0];
                           sdaOe_ff <= 1'b1;
                           state_ff <= ST_ACKA;
                        end else begin
                           state_ff <= ST_IDLE;                      // not ours, stay quiet
                        end
                     end else begin
                        sdaOe_ff <= 1'b1;
                        state_ff <= ST_ACKW;
                        if (!gotPtr_ff) begin
                           ptr_ff    <= shift_ff;
                           gotPtr_ff <= 1'b1;
                        end else begin
                           ptr_ff <= ptr_ff + 8'h01;
                        end
                     end
                  end
               end
               ST_ACKA: begin
                  if (sclFall) begin
                     if (rnw_ff) begin
                        shift_ff <= rdData;
                        ptr_ff   <= ptr_ff + 8'h01;
                        sdaOe_ff <= ~rdData[7];
                        state_ff <= ST_RD;
                     end else begin
                        sdaOe_ff <= 1'b0;
                        state_ff <= ST_WR;
                     end
                  end
               end
               ST_ACKW: if (sclFall) begin
                  sdaOe_ff <= 1'b0;
                  state_ff <= ST_WR;
               end
               ST_RD: begin
                  if (sclFall) begin
                     if (bitCnt_ff == 4'd7) begin
                        bitCnt_ff <= 4'd0;
                        sdaOe_ff  <= 1'b0;                           // let the master answer
                        state_ff  <= ST_RACK;
                     end else begin
                        bitCnt_ff <= bitCnt_ff + 4'd1;
                        shift_ff  <= {shift_ff[6:0], 1'b0};
                        sdaOe_ff  <= ~shift_ff[6];
                     end
                  end
               end
               ST_RACK: begin
                  if (sclRise) begin
                     rnw_ff <= ~sdaIn;                               // nack ends the burst
                  end else if (sclFall) begin
                     if (rnw_ff) begin
                        shift_ff <= rdData;
                        ptr_ff   <= ptr_ff + 8'h01;
                        sdaOe_ff <= ~rdData[7];
                        state_ff <= ST_RD;
                     end else begin
                        state_ff <= ST_IDLE;
                     end
                  end
               end
               default: state_ff <= ST_IDLE;
            endcase
         end
      end
   end

   // command and status registers; soft reset takes them back too
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         play_ff        <= `DCS_RST_PLAYBACK;
         silence_ff     <= `DCS_RST_SILENCE;
         ancCmd_ff      <= `DCS_RST_ANC_CMD;
         pinSel_ff      <= `DCS_RST_PIN_SELECT;
         syncState_ff   <= 2'h0;
         ancCount_ff    <= 16'h0000;
         header_ff      <= 21'h00000;
         ancBuf_ff      <= 40'h0000000000;
         softResetPulse <= 1'b0;
         ancLatchPulse  <= 1'b0;
      end else begin
         softResetPulse <= 1'b0;
         ancLatchPulse  <= 1'b0;
         if (wrStb && ptr_ff == `DCS_SOFT_RESET_TRIGGER) begin
            // any value written resets, bit0 included
            softResetPulse <= 1'b1;
            play_ff        <= `DCS_RST_PLAYBACK;
            silence_ff     <= `DCS_RST_SILENCE;
            ancCmd_ff      <= `DCS_RST_ANC_CMD;
            pinSel_ff      <= `DCS_RST_PIN_SELECT;
            syncState_ff   <= 2'h0;
            ancCount_ff    <= 16'h0000;
            header_ff      <= 21'h00000;
            ancBuf_ff      <= 40'h0000000000;
         end else begin
            // status capture from the core; writes to these are dropped
            if (syncStateIn != `DCS_SYNC_UNUSED) begin
               syncState_ff <= syncStateIn;
            end
            if (frameDecodedOk) begin
               ancCount_ff <= ancCountIn;
            end
            if (syncAchieved) begin
               header_ff <= headerIn;
            end
            if (wrStb) begin
               case (ptr_ff)
                  `DCS_PLAYBACK_REQUEST:    play_ff    <= shift_ff;
                  `DCS_OUTPUT_SILENCE:      silence_ff <= shift_ff;
                  `DCS_REQUEST_PIN_SELECT:  pinSel_ff  <= shift_ff;
                  `DCS_ANCILLARY_LATCH_COMMAND: begin
                     ancCmd_ff <= shift_ff;
                     if (shift_ff != 8'h00) begin
                        ancBuf_ff     <= ancDataIn;
                        ancLatchPulse <= 1'b1;
                     end
                  end
                  default: ;                                         // read-only and reserved writes dropped
               endcase
            end
         end
      end
   end

   // play only counts in the decoding state; silence leaves clocks alone
   assign playActive = play_ff[`DCS_PLAY_BIT] & decoding;
   assign silenceOut = silence_ff[`DCS_SILENCE_BIT];

   // pin mux passes the crystal clock itself, so frequency is identical
   assign multimediaPin = pinSel_ff[`DCS_PIN_SELECT_BIT] ? dataRequestIn : crystalInputClock;

   // header field decode, registered
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         standardVariant  <= 2'h0;
         bitrateKbps      <= 9'h000;
         bitrateFree      <= 1'b0;
         bitrateForbidden <= 1'b0;
         layerThree       <= 1'b0;
         crcAbsent        <= 1'b0;
      end else begin
         standardVariant  <= {header_ff[`DCS_HDR_EXT_VERSION_BIT], header_ff[`DCS_HDR_VERSION_BIT]};
         layerThree       <= header_ff[`DCS_HDR_LAYER_MSB:`DCS_HDR_LAYER_LSB] == `DCS_LAYER_THREE;
         crcAbsent        <= header_ff[`DCS_HDR_PROTECT_BIT];
         bitrateFree      <= header_ff[`DCS_HDR_BITRATE_MSB:`DCS_HDR_BITRATE_LSB] == `DCS_BITRATE_FREE;
         bitrateForbidden <= header_ff[`DCS_HDR_BITRATE_MSB:`DCS_HDR_BITRATE_LSB] == `DCS_BITRATE_FORBIDDEN;
         bitrateKbps      <= rateOf(header_ff[`DCS_HDR_VERSION_BIT],
                                    header_ff[`DCS_HDR_BITRATE_MSB:`DCS_HDR_BITRATE_LSB]);
      end
   end

   // bitrate table; free and forbidden give zero
   function [8:0] rateOf;
      input       ver;
      input [3:0] idx;
      begin
         case (idx)
            4'h1:    rateOf = ver ? 9'h020 : 9'h008;
            4'h2:    rateOf = ver ? 9'h028 : 9'h010;
            4'h3:    rateOf = ver ? 9'h030 : 9'h018;
            4'h4:    rateOf = ver ? 9'h038 : 9'h020;
            4'h5:    rateOf = ver ? 9'h040 : 9'h028;
            4'h6:    rateOf = ver ? 9'h050 : 9'h030;
            4'h7:    rateOf = ver ? 9'h060 : 9'h038;
            4'h8:    rateOf = ver ? 9'h070 : 9'h040;
            4'h9:    rateOf = ver ? 9'h080 : 9'h050;
            4'hA:    rateOf = ver ? 9'h0A0 : 9'h060;
            4'hB:    rateOf = ver ? 9'h0C0 : 9'h070;
            4'hC:    rateOf = ver ? 9'h0E0 : 9'h080;
            4'hD:    rateOf = ver ? 9'h100 : 9'h090;
            4'hE:    rateOf = ver ? 9'h140 : 9'h0A0;
            default: rateOf = 9'h000;
         endcase
      end
   endfunction

endmodule // dcs_regs

//--- hw/dcs_map.vh
`ifndef DCS_MAP_VH
`define DCS_MAP_VH
// register offsets on the control bus
`define DCS_SOFT_RESET_TRIGGER      8'h10
`define DCS_PLAYBACK_REQUEST        8'h13
`define DCS_OUTPUT_SILENCE          8'h14
`define DCS_ANCILLARY_LATCH_COMMAND 8'h16
`define DCS_REQUEST_PIN_SELECT      8'h18
`define DCS_FRAME_SYNC_STATE        8'h40
`define DCS_ANCILLARY_BITS_LOW      8'h41
`define DCS_ANCILLARY_BITS_HIGH     8'h42
`define DCS_FRAME_HEADER_UPPER      8'h43
`define DCS_FRAME_HEADER_MIDDLE     8'h44
`define DCS_FRAME_HEADER_LOWER      8'h45
`define DCS_ANC_BUF_FIRST           8'h59
`define DCS_ANC_BUF_LAST            8'h5D
// reset values
`define DCS_RST_SOFT_RESET          8'h00
`define DCS_RST_PLAYBACK            8'h01
`define DCS_RST_SILENCE             8'h00
`define DCS_RST_ANC_CMD             8'h00
`define DCS_RST_PIN_SELECT          8'h00
`define DCS_RST_STATUS              8'h00
// field positions
`define DCS_SOFT_RESET_BIT          0
`define DCS_PLAY_BIT                0
`define DCS_SILENCE_BIT             0
`define DCS_PIN_SELECT_BIT          2
`define DCS_HDR_BITRATE_MSB         15
`define DCS_HDR_BITRATE_LSB         12
`define DCS_HDR_PROTECT_BIT         16
`define DCS_HDR_LAYER_MSB           18
`define DCS_HDR_LAYER_LSB           17
`define DCS_HDR_VERSION_BIT         19
`define DCS_HDR_EXT_VERSION_BIT     20
// field codes
`define DCS_LAYER_THREE             2'h1
`define DCS_SYNC_UNUSED             2'h3
`define DCS_BITRATE_FREE            4'h0
`define DCS_BITRATE_FORBIDDEN       4'hF
`endif

//--- verification/dcs_regs_monitor.sv
`timescale 1ns/10ps
module dcs_regs_monitor (
   // clock and reset
   input wire        mclk,
   input wire        rst_n,
   // core side
   input wire        decoding,
   input wire        syncAchieved,
   input wire [20:0] headerIn,
   // control outputs
   input wire        softResetPulse,
   input wire        playActive,
   input wire        silenceOut,
   input wire        ancLatchPulse,
   // multimedia pin
   input wire        crystalInputClock,
   input wire        dataRequestIn,
   input wire        multimediaPin,
   // header decode
   input wire [1:0]  standardVariant,
   input wire [8:0]  bitrateKbps,
   input wire        bitrateFree,
   input wire        bitrateForbidden,
   input wire        layerThree,
   input wire        crcAbsent
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   reg [20:0] hdr_ff;
   // header as offered at the last sync; decode lags it by a cycle
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         hdr_ff <= 21'h0;
      else if (syncAchieved)
         hdr_ff <= headerIn;
   end
   // kbit/s table, piecewise linear per version bit
   function automatic [8:0] kbps(input v, input [3:0] i);
      if (i == 4'h0 || i == 4'hF) kbps = 9'h0;
      else if (!v) kbps = (i < 4'h9) ? 9'h8 * i : 9'h10 * i - 9'h40;
      else if (i < 4'h6) kbps = 9'h8 * i + 9'h18;
      else if (i < 4'hA) kbps = 9'h10 * i - 9'h10;
      else if (i < 4'hE) kbps = 9'h20 * i - 9'hA0;
      else kbps = 9'h140;
   endfunction
   property p_srst_pulse; softResetPulse |=> !softResetPulse; endproperty
   a_srst_pulse: assert property (p_srst_pulse) else $error("soft reset pulse too long");
   property p_srst_clear; softResetPulse |-> ##1 !silenceOut; endproperty
   a_srst_clear: assert property (p_srst_clear) else $error("silence kept over soft reset");
   property p_anc_pulse; ancLatchPulse |=> !ancLatchPulse; endproperty
   a_anc_pulse: assert property (p_anc_pulse) else $error("latch pulse too long");
   property p_rst_vals; $rose(rst_n) |-> !silenceOut && !softResetPulse && !ancLatchPulse; endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("outputs not at reset level");
   property p_play; !decoding |-> !playActive; endproperty
   a_play: assert property (p_play) else $error("playback active outside decoding");
   property p_pin; multimediaPin == crystalInputClock || multimediaPin == dataRequestIn; endproperty
   a_pin: assert property (p_pin) else $error("multimedia pin from neither source");
   property p_variant; syncAchieved |-> ##2 standardVariant == hdr_ff[20:19]; endproperty
   a_variant: assert property (p_variant) else $error("variant decode wrong");
   property p_layer; syncAchieved |-> ##2 layerThree == (hdr_ff[18:17] == 2'h1); endproperty
   a_layer: assert property (p_layer) else $error("layer decode wrong");
   property p_crc; syncAchieved |-> ##2 crcAbsent == hdr_ff[16]; endproperty
   a_crc: assert property (p_crc) else $error("protection decode wrong");
   property p_rate;
      syncAchieved |-> ##2 bitrateKbps == kbps(hdr_ff[19], hdr_ff[15:12]) &&
         bitrateFree == (hdr_ff[15:12] == 4'h0) && bitrateForbidden == (hdr_ff[15:12] == 4'hF);
   endproperty
   a_rate: assert property (p_rate) else $error("bitrate decode wrong");
endmodule // dcs_regs_monitor
bind dcs_regs dcs_regs_monitor mon (.*);

//--- verification/dcs_host_model.sv
`timescale 1ns/10ps
module dcs_host_model #(
   parameter [6:0] DEV = 7'h43   // arbitrary bus address
) (
   // clock and bus
   input  wire       mclk,
   input  wire       sdaBus,
   output reg        scl,
   output reg        sdaDrv,
   // read results
   output reg  [7:0] rdData,
   output reg        rdDone,
   output reg  [7:0] nackCnt
);
   // idle bus, both lines released
   initial begin
      scl = 1'h1;
      sdaDrv = 1'h1;
      rdDone = 1'h0;
      nackCnt = 8'h0;
   end
   // move just after an edge so the device never sees a race
   task tick(input integer n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // data changes only while the clock is low
   task bitx(input b, output r);
      sdaDrv = b;
      tick(3);
      scl = 1'h1;
      tick(4);
      r = sdaBus;
      scl = 1'h0;
      tick(1);
   endtask
   // start, also serves as repeated start
   task start;
      sdaDrv = 1'h1;
      tick(2);
      scl = 1'h1;
      tick(4);
      sdaDrv = 1'h0;
      tick(4);
      scl = 1'h0;
      tick(1);
   endtask
   task stop;
      sdaDrv = 1'h0;
      tick(3);
      scl = 1'h1;
      tick(4);
      sdaDrv = 1'h1;
      tick(4);
   endtask
   // a high ninth bit is a refusal and is counted
   task wbyte(input [7:0] w);
      reg r;
      integer i;
      for (i = 7; i >= 0; i = i - 1) bitx(w[i], r);
      bitx(1'h1, r);
      if (r) nackCnt = nackCnt + 8'h1;
   endtask
   // host acks every byte but the last
   task rbyte(input last);
      reg r;
      integer i;
      for (i = 7; i >= 0; i = i - 1) begin
         bitx(1'h1, r);
         rdData[i] = r;
      end
      bitx(last, r);
      rdDone = 1'h1;
      tick(1);
      rdDone = 1'h0;
   endtask
   task wr(input [7:0] a, input [7:0] d);
      start;
      wbyte({DEV, 1'h0});
      wbyte(a);
      wbyte(d);
      stop;
   endtask
   task rd(input [7:0] a, input integer n);
      integer k;
      start;
      wbyte({DEV, 1'h0});
      wbyte(a);
      start;
      wbyte({DEV, 1'h1});
      for (k = 1; k <= n; k = k + 1) rbyte(k == n);
      stop;
   endtask
endmodule // dcs_host_model

//--- verification/tb.sv
`timescale 1ns/10ps
module tb;
   reg         mclk, rst_n, decoding, syncAchieved, frameDecodedOk, xtal, dataReq;
   reg  [1:0]  syncStateIn;
   reg  [20:0] headerIn, h;
   reg  [15:0] ancCountIn;
   reg  [39:0] ancDataIn, d;
   reg  [7:0]  expQ [$];
   wire        scl, sdaDrv, sdaOe, rdDone, playActive, silenceOut, srPulse, alPulse, mmPin;
   wire [7:0]  rdData, nackCnt;
   wire        sdaBus = sdaDrv & ~sdaOe;   // open drain, pulled up when released
   integer     seed, err_count, checked, srCnt, alCnt, n, i, k;
   localparam [87:0] REGS = 88'h10_13_14_16_18_40_41_42_43_44_45;
   dcs_regs #(.DEV_ADDR(7'h43)) dut (.mclk(mclk), .rst_n(rst_n), .sclIn(scl), .sdaIn(sdaBus), .sdaOut(),
      .sdaOe(sdaOe), .decoding(decoding), .syncStateIn(syncStateIn), .syncAchieved(syncAchieved),
      .headerIn(headerIn), .frameDecodedOk(frameDecodedOk), .ancCountIn(ancCountIn), .ancDataIn(ancDataIn),
      .softResetPulse(srPulse), .playActive(playActive), .silenceOut(silenceOut), .ancLatchPulse(alPulse),
      .crystalInputClock(xtal), .dataRequestIn(dataReq), .multimediaPin(mmPin), .standardVariant(),
      .bitrateKbps(), .bitrateFree(), .bitrateForbidden(), .layerThree(), .crcAbsent());
   dcs_host_model #(.DEV(7'h43)) host (.mclk(mclk), .sdaBus(sdaBus), .scl(scl), .sdaDrv(sdaDrv),
      .rdData(rdData), .rdDone(rdDone), .nackCnt(nackCnt));
   initial begin
      mclk = 1'h0;
      forever #5 mclk = ~mclk;
   end
   // pass-through sources move every cycle, pulses are counted
   always @(posedge mclk) begin
      #1 xtal <= ~xtal;
      dataReq <= 1'($random(seed));
      srCnt = srCnt + (srPulse === 1'h1);
      alCnt = alCnt + (alPulse === 1'h1);
   end
   task chk(input [15:0] got, input [15:0] exp);
      checked = checked + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // each byte read back is matched to the oldest note
   always @(posedge mclk) if (rdDone === 1'h1) chk(rdData, expQ.pop_front());
   task rdx(input [7:0] a, input [7:0] e);
      expQ.push_back(e);
      host.rd(a, 1);
   endtask
   // core offers a header and a count together
   task core(input [20:0] hv, input [15:0] c);
      headerIn = hv;
      ancCountIn = c;
      syncAchieved = 1'h1;
      frameDecodedOk = 1'h1;
      @(posedge mclk) #1;
      syncAchieved = 1'h0;
      frameDecodedOk = 1'h0;
      repeat (3) @(posedge mclk) #1;
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge mclk);
      err_count = err_count + 1;
      finish_test;
   end
   initial begin
      {seed, err_count, checked, srCnt, alCnt} = {32'h3E0A, 128'h0};
      {rst_n, decoding, syncAchieved, frameDecodedOk, xtal, dataReq} = 6'h0;
      {syncStateIn, headerIn, ancCountIn, ancDataIn} = 79'h0;
      repeat (10) @(posedge mclk);
      #1 rst_n = 1'h1;
      for (i = 0; i < 11; i = i + 1) rdx(REGS[8*i +: 8], REGS[8*i +: 8] == 8'h13);
      $display("reset values done");
      for (i = 0; i < 4; i = i + 1) begin
         decoding = 1'($random(seed));
         host.wr(8'h13, {7'h0, i[0]});
         host.wr(8'h14, {7'h0, i[1]});
         host.wr(8'h18, {5'h0, i[0], 2'h0});
         #3;
         chk(playActive, i[0] & decoding);
         chk(silenceOut, i[1]);
         chk(mmPin, i[0] ? dataReq : xtal);
         rdx(8'h18, {5'h0, i[0], 2'h0});
      end
      $display("control registers done");
      syncStateIn = 2'h2;
      rdx(8'h40, 8'h02);
      syncStateIn = 2'h3;
      rdx(8'h40, 8'h02);
      syncStateIn = 2'h1;
      rdx(8'h40, 8'h01);
      syncStateIn = 2'h3;
      for (i = 0; i < 16; i = i + 1) begin
         h = $random(seed);
         h[15:12] = i[3:0];
         if (i[0]) h[18:17] = 2'h1;
         core(h, 16'($random(seed)));
      end
      expQ.push_back(ancCountIn[7:0]);
      expQ.push_back(ancCountIn[15:8]);
      for (k = 0; k < 3; k = k + 1) expQ.push_back(k == 0 ? {3'h0, h[20:16]} : h[23-8*k -: 8]);
      host.rd(8'h41, 5);
      headerIn = ~h;
      for (k = 0; k < 3; k = k + 1) expQ.push_back(k == 0 ? {3'h0, h[20:16]} : h[23-8*k -: 8]);
      host.rd(8'h43, 3);
      $display("status registers done");
      d = {$random(seed), $random(seed)};
      ancDataIn = d;
      n = alCnt;
      host.wr(8'h16, 8'h01);
      chk(16'(alCnt - n), 16'h1);
      for (k = 0; k < 5; k = k + 1) expQ.push_back(d[8*k +: 8]);
      host.rd(8'h59, 5);
      ancDataIn = ~d;
      host.wr(8'h16, 8'h00);
      chk(16'(alCnt - n), 16'h1);
      rdx(8'h5A, d[15:8]);
      $display("ancillary buffer done");
      host.wr(8'h13, 8'h00);
      host.wr(8'h14, 8'h01);
      host.wr(8'h16, 8'h03);
      n = srCnt;
      host.wr(8'h10, 8'hFE);
      chk(16'(srCnt - n), 16'h1);
      rdx(8'h13, 8'h01);
      rdx(8'h14, 8'h00);
      rdx(8'h16, 8'h00);
      rdx(8'h18, 8'h00);
      chk(silenceOut, 16'h0);
      for (k = 0; k < 6; k = k + 1) expQ.push_back(8'h00);
      host.rd(8'h40, 6);
      rdx(8'h59, 8'h00);
      chk(nackCnt, 8'h0);
      chk(expQ.size(), 16'h0);
      $display("soft reset done");
      finish_test;
   end
endmodule // tb
